/* File: verilog/fail_safe_monitor_top.v */
// fail-safe clock monitor, clock source switch and oscillator status registers
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`include "fail_safe_monitor_defines.vh"
// Contract
// R01: monitor external clock in every external mode
// R02: sample clock is low-freq osc over 64
// R03: ext falling sets latch, sample rise clears
// R04: fail when sample half period lacks low
// R05: failure forces current source to high-freq
// R06: divider and frequency left untouched on failover
// R07: set fail flag, request interrupt if enabled
// R08: stay internal until software requests new source
// R09: reset, sleep or request change clears failsafe
// R10: external switch restarts timer, stays on current
// R11: failsafe ends on switch, persistent fail reflags
// R12: software clears fail flag before switching back
// R13: monitoring waits for timer, skipped in clock-input
// R14: three-bit source code map, three reserved codes
// R15: divider code is power of two, max 512; codes above 9 are stored unchecked
// R16: reserved source write ignored entirely
// R17: switch disallowed makes request read-only
// R18: reset source setting picks source and divider
// R19: hold bit delays switch and raises interrupt
// R20: done flag when request equals current
// R21: new-ready flag set while switch waits
// R22: power select bit drives secondary high power
// R23: status bits show each oscillator ready
// R24: failure synchronised to low-freq domain first
module fail_safe_monitor_top #(
  parameter OST_COUNT = `FAIL_SAFE_MONITOR_OST_DEFAULT
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // avalon-mm slave
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // oscillator pins and ready indications
  input wire ext_clk,
  input wire low_freq_internal_osc,
  input wire [7:0] osc_ready_in,
  // configuration straps
  input wire fail_monitor_enable,
  input wire switch_allow_config,
  input wire external_clock_input_mode,
  input wire [2:0] reset_source_config,
  // power management
  input wire sleep_pulse,
  // clock selection outputs
  output wire [2:0] system_source,
  output wire [3:0] system_divider,
  output wire secondary_high_power,
  output wire high_freq_64m_default,
  // events
  output wire osc_fail_request,
  output wire switch_hold_request,
  output wire fail_safe_active
);

  localparam SYN_W = 16;
  localparam OST_W = 16;
  localparam [OST_W-1:0] OST_LAST = OST_COUNT - 1;

  reg [1:0] rst_sync_reg;
  wire rst_n;
  wire [SYN_W-1:0] syn_in;
  wire [SYN_W-1:0] syn_out;
  reg init_done_reg;
  reg [1:0] init_wait_reg;
  reg ext_prev_reg;
  reg lf_prev_reg;
  reg [`FAIL_SAFE_MONITOR_LF_CNT_W-1:0] lf_cnt_reg;
  reg latch_reg;
  reg fail_safe_reg;
  reg fail_flag_reg;
  reg fail_ie_reg;
  reg [2:0] req_src_reg;
  reg [3:0] req_div_reg;
  reg [2:0] cur_src_reg;
  reg [3:0] cur_div_reg;
  reg hold_reg;
  reg pwr_reg;
  reg new_rdy_reg;
  reg hf64_reg;
  reg [OST_W-1:0] ost_cnt_reg;
  reg ost_done_reg;
  reg ack_reg;
  reg [7:0] rd_next;
  reg src_ready;
  wire [2:0] strap;
  wire [7:0] rdy;
  wire ext_fall;
  wire lf_tick;
  wire sample_rise;
  wire sample_fall;
  wire cur_external;
  wire monitor_on;
  wire fail_event;
  wire do_write;
  wire wr_req;
  wire wr_ctrl;
  wire wr_fail;
  wire [2:0] wr_src;
  wire [3:0] wr_div;
  wire src_reserved;
  wire req_change;
  wire req_external;
  wire switching;
  wire ost_restart;
  wire [7:0] status_val;

  // reset released through two flops
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // every pin-side input crosses two flops per bit
  assign syn_in = {reset_source_config, low_freq_internal_osc, ext_clk,
                   fail_monitor_enable, switch_allow_config, external_clock_input_mode,
                   osc_ready_in};
  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi = gi + 1)
    begin : g_sync
      reg s0_reg;
      reg s1_reg;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s0_reg <= 1'b0;
          s1_reg <= 1'b0;
        end
        else
        begin
          s0_reg <= syn_in[gi];
          s1_reg <= s0_reg;
        end
      end
      assign syn_out[gi] = s1_reg;
    end
  endgenerate

  assign strap = syn_out[15:13];
  assign rdy = syn_out[7:0];
  wire lf_s = syn_out[12];
  wire ext_s = syn_out[11];
  wire fme_s = syn_out[10];
  wire swen_s = syn_out[9];
  wire ecm_s = syn_out[8];

  // edge detection on the synchronised copies only
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_prev_reg <= 1'b0;
      lf_prev_reg <= 1'b0;
      init_wait_reg <= 2'b00;
    end
    else
    begin
      ext_prev_reg <= ext_s;
      lf_prev_reg <= lf_s;
      init_wait_reg <= {init_wait_reg[0], 1'b1};
    end
  end
  assign ext_fall = ext_prev_reg & ~ext_s;
  assign lf_tick = lf_s & ~lf_prev_reg;

  // sample clock as a phase counter of low-freq ticks
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lf_cnt_reg <= {`FAIL_SAFE_MONITOR_LF_CNT_W{1'b0}};
    else if (lf_tick)
      lf_cnt_reg <= lf_cnt_reg + 1'b1; // R02
  end
  assign sample_rise = lf_tick & (lf_cnt_reg == `FAIL_SAFE_MONITOR_LF_RISE);
  assign sample_fall = lf_tick & (lf_cnt_reg == `FAIL_SAFE_MONITOR_LF_FALL);

  // set wins, so an ext edge beside a sample edge is not lost
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      latch_reg <= 1'b0;
    else if (ext_fall)
      latch_reg <= 1'b1; // R03
    else if (sample_rise)
      latch_reg <= 1'b0; // R03
  end

  assign cur_external = (cur_src_reg == `FAIL_SAFE_MONITOR_SRC_EXT) | (cur_src_reg == `FAIL_SAFE_MONITOR_SRC_PLL) |
                        (cur_src_reg == `FAIL_SAFE_MONITOR_SRC_SEC); // R01
  assign monitor_on = fme_s & ost_done_reg & cur_external & ~fail_safe_reg & init_done_reg; // R13
  // decided only on a low-freq tick so the forced change follows that clock
  assign fail_event = monitor_on & sample_fall & ~latch_reg & ~ext_fall; // R04 R24

  // avalon: one wait cycle, request taken at the edge with waitrequest low
  assign waitrequest = (read | write) & ~ack_reg;
  assign do_write = write & ack_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= (read | write) & ~ack_reg;
  end

  assign wr_req = do_write & byteenable[0] & (address == `FAIL_SAFE_MONITOR_OFS_REQUEST);
  assign wr_ctrl = do_write & byteenable[0] & (address == `FAIL_SAFE_MONITOR_OFS_SWCTRL);
  assign wr_fail = do_write & byteenable[0] & (address == `FAIL_SAFE_MONITOR_OFS_FAIL);
  assign wr_src = writedata[`FAIL_SAFE_MONITOR_SRC_HI:`FAIL_SAFE_MONITOR_SRC_LO];
  assign wr_div = writedata[`FAIL_SAFE_MONITOR_DIV_HI:`FAIL_SAFE_MONITOR_DIV_LO];
  assign src_reserved = (wr_src == `FAIL_SAFE_MONITOR_SRC_RSV3) | (wr_src == `FAIL_SAFE_MONITOR_SRC_RSV1) |
                        (wr_src == `FAIL_SAFE_MONITOR_SRC_RSV0); // R14
  assign req_change = wr_req & swen_s & ~src_reserved &
                      ((wr_src != req_src_reg) | (wr_div != req_div_reg)); // R16 R17
  assign req_external = (wr_src == `FAIL_SAFE_MONITOR_SRC_EXT) | (wr_src == `FAIL_SAFE_MONITOR_SRC_PLL);
  assign ost_restart = ~init_done_reg | sleep_pulse | (req_change & req_external); // R10
  assign switching = (req_src_reg != cur_src_reg) | (req_div_reg != cur_div_reg);

  // start-up timer counts external falling edges
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ost_cnt_reg <= {OST_W{1'b0}};
      ost_done_reg <= 1'b0;
    end
    else if (ost_restart)
    begin
      ost_cnt_reg <= {OST_W{1'b0}};
      ost_done_reg <= ecm_s; // R13
    end
    else if (ecm_s)
      ost_done_reg <= 1'b1; // R13
    else if (ext_fall & ~ost_done_reg)
    begin
      ost_cnt_reg <= ost_cnt_reg + 1'b1;
      if (ost_cnt_reg == OST_LAST)
        ost_done_reg <= 1'b1;
    end
  end

  // readiness of the requested source
  always @*
  begin
    src_ready = 1'b0;
    case (req_src_reg)
      `FAIL_SAFE_MONITOR_SRC_EXT: src_ready = rdy[`FAIL_SAFE_MONITOR_ST_EXT] & ost_done_reg;
      `FAIL_SAFE_MONITOR_SRC_HF: src_ready = rdy[`FAIL_SAFE_MONITOR_ST_HF];
      `FAIL_SAFE_MONITOR_SRC_LF: src_ready = rdy[`FAIL_SAFE_MONITOR_ST_LF];
      `FAIL_SAFE_MONITOR_SRC_SEC: src_ready = rdy[`FAIL_SAFE_MONITOR_ST_SEC];
      `FAIL_SAFE_MONITOR_SRC_PLL: src_ready = rdy[`FAIL_SAFE_MONITOR_ST_PLL] & ost_done_reg;
      default: src_ready = 1'b0;
    endcase
  end

  // request, current and switch control
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_done_reg <= 1'b0;
      req_src_reg <= `FAIL_SAFE_MONITOR_SRC_HF;
      req_div_reg <= `FAIL_SAFE_MONITOR_DIV_4;
      cur_src_reg <= `FAIL_SAFE_MONITOR_SRC_HF;
      cur_div_reg <= `FAIL_SAFE_MONITOR_DIV_4;
      hf64_reg <= 1'b0;
      hold_reg <= 1'b0;
      pwr_reg <= 1'b0;
      new_rdy_reg <= 1'b0;
      fail_safe_reg <= 1'b0;
    end
    else if (!init_wait_reg[1])
      init_done_reg <= 1'b0; // straps still in flight, loading now would take the flop reset value
    else if (!init_done_reg)
    begin
      // straps have settled through the synchroniser by now
      init_done_reg <= 1'b1;
      hf64_reg <= 1'b0;
      case (strap)
        `FAIL_SAFE_MONITOR_SRC_EXT, `FAIL_SAFE_MONITOR_SRC_LF, `FAIL_SAFE_MONITOR_SRC_SEC, `FAIL_SAFE_MONITOR_SRC_PLL:
        begin
          req_src_reg <= strap; // R18
          cur_src_reg <= strap;
          req_div_reg <= `FAIL_SAFE_MONITOR_DIV_1;
          cur_div_reg <= `FAIL_SAFE_MONITOR_DIV_1;
        end
        `FAIL_SAFE_MONITOR_SRC_RSV0:
        begin
          req_src_reg <= `FAIL_SAFE_MONITOR_SRC_HF; // R18
          cur_src_reg <= `FAIL_SAFE_MONITOR_SRC_HF;
          req_div_reg <= `FAIL_SAFE_MONITOR_DIV_1;
          cur_div_reg <= `FAIL_SAFE_MONITOR_DIV_1;
          hf64_reg <= 1'b1;
        end
        default:
        begin
          req_src_reg <= `FAIL_SAFE_MONITOR_SRC_HF; // R18
          cur_src_reg <= `FAIL_SAFE_MONITOR_SRC_HF;
          req_div_reg <= `FAIL_SAFE_MONITOR_DIV_4;
          cur_div_reg <= `FAIL_SAFE_MONITOR_DIV_4;
        end
      endcase
    end
    else
    begin
      if (req_change)
      begin
        req_src_reg <= wr_src; // R16
        req_div_reg <= wr_div; // R15
      end
      if (wr_ctrl)
      begin
        hold_reg <= writedata[`FAIL_SAFE_MONITOR_BIT_HOLD];
        pwr_reg <= writedata[`FAIL_SAFE_MONITOR_BIT_PWR]; // R22
      end
      if (fail_event)
      begin
        cur_src_reg <= `FAIL_SAFE_MONITOR_SRC_HF; // R05 R06
        fail_safe_reg <= 1'b1;
        new_rdy_reg <= 1'b0;
      end
      else if (req_change | sleep_pulse)
      begin
        fail_safe_reg <= 1'b0; // R09 R11
        new_rdy_reg <= 1'b0;
      end
      else if (switching & ~fail_safe_reg)
      begin
        if (!new_rdy_reg)
          new_rdy_reg <= src_ready; // R21
        else if (!hold_reg)
        begin
          cur_src_reg <= req_src_reg; // R19 R10
          cur_div_reg <= req_div_reg;
          new_rdy_reg <= 1'b0; // R21
        end
      end
      else
        new_rdy_reg <= 1'b0; // R08
    end
  end

  // fail flag: hardware set beats a software clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_flag_reg <= 1'b0;
      fail_ie_reg <= 1'b0;
    end
    else
    begin
      if (wr_fail)
        fail_ie_reg <= writedata[`FAIL_SAFE_MONITOR_FAIL_IE];
      if (fail_event)
        fail_flag_reg <= 1'b1; // R07 R11
      else if (wr_fail & writedata[`FAIL_SAFE_MONITOR_FAIL_FLAG])
        fail_flag_reg <= 1'b0; // R12
    end
  end

  assign status_val = rdy & `FAIL_SAFE_MONITOR_ST_MASK; // R23

  // read mux, loaded one edge before the taking edge
  always @*
  begin
    rd_next = `FAIL_SAFE_MONITOR_ZERO8;
    case (address)
      `FAIL_SAFE_MONITOR_OFS_REQUEST: rd_next = {1'b0, req_src_reg, req_div_reg};
      `FAIL_SAFE_MONITOR_OFS_CURRENT: rd_next = {1'b0, cur_src_reg, cur_div_reg};
      `FAIL_SAFE_MONITOR_OFS_SWCTRL:
      begin
        rd_next[`FAIL_SAFE_MONITOR_BIT_HOLD] = hold_reg;
        rd_next[`FAIL_SAFE_MONITOR_BIT_PWR] = pwr_reg;
        rd_next[`FAIL_SAFE_MONITOR_BIT_DONE] = ~switching; // R20
        rd_next[`FAIL_SAFE_MONITOR_BIT_NEWRDY] = new_rdy_reg;
      end
      `FAIL_SAFE_MONITOR_OFS_STATUS: rd_next = status_val;
      `FAIL_SAFE_MONITOR_OFS_FAIL:
      begin
        rd_next[`FAIL_SAFE_MONITOR_FAIL_FLAG] = fail_flag_reg;
        rd_next[`FAIL_SAFE_MONITOR_FAIL_IE] = fail_ie_reg;
        rd_next[`FAIL_SAFE_MONITOR_FAIL_ACTIVE] = fail_safe_reg;
      end
      default: rd_next = `FAIL_SAFE_MONITOR_ZERO8;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      readdata <= 32'h0000_0000;
    else if (read & ~ack_reg)
      readdata <= {24'h00_0000, rd_next};
  end

  assign system_source = cur_src_reg;
  assign system_divider = cur_div_reg;
  assign secondary_high_power = pwr_reg; // R22
  assign high_freq_64m_default = hf64_reg;
  assign osc_fail_request = fail_flag_reg & fail_ie_reg; // R07
  assign switch_hold_request = new_rdy_reg & hold_reg; // R19
  assign fail_safe_active = fail_safe_reg;

endmodule // fail_safe_monitor_top

/* File: verilog/fail_safe_monitor_defines.vh */
// constants for the fail-safe clock monitor and clock switch
`ifndef FAIL_SAFE_MONITOR_DEFINES_VH
`define FAIL_SAFE_MONITOR_DEFINES_VH
`define FAIL_SAFE_MONITOR_OFS_REQUEST 5'h00
`define FAIL_SAFE_MONITOR_OFS_CURRENT 5'h04
`define FAIL_SAFE_MONITOR_OFS_SWCTRL 5'h08
`define FAIL_SAFE_MONITOR_OFS_STATUS 5'h0C
`define FAIL_SAFE_MONITOR_OFS_FAIL 5'h10
`define FAIL_SAFE_MONITOR_SRC_EXT 3'h7
`define FAIL_SAFE_MONITOR_SRC_HF 3'h6
`define FAIL_SAFE_MONITOR_SRC_LF 3'h5
`define FAIL_SAFE_MONITOR_SRC_SEC 3'h4
`define FAIL_SAFE_MONITOR_SRC_RSV3 3'h3
`define FAIL_SAFE_MONITOR_SRC_PLL 3'h2
`define FAIL_SAFE_MONITOR_SRC_RSV1 3'h1
`define FAIL_SAFE_MONITOR_SRC_RSV0 3'h0
`define FAIL_SAFE_MONITOR_DIV_1 4'h0
`define FAIL_SAFE_MONITOR_DIV_4 4'h2
`define FAIL_SAFE_MONITOR_DIV_MAX 4'h9
`define FAIL_SAFE_MONITOR_SRC_HI 6
`define FAIL_SAFE_MONITOR_SRC_LO 4
`define FAIL_SAFE_MONITOR_DIV_HI 3
`define FAIL_SAFE_MONITOR_DIV_LO 0
`define FAIL_SAFE_MONITOR_BIT_HOLD 7
`define FAIL_SAFE_MONITOR_BIT_PWR 6
`define FAIL_SAFE_MONITOR_BIT_DONE 4
`define FAIL_SAFE_MONITOR_BIT_NEWRDY 3
`define FAIL_SAFE_MONITOR_ST_EXT 7
`define FAIL_SAFE_MONITOR_ST_HF 6
`define FAIL_SAFE_MONITOR_ST_MF 5
`define FAIL_SAFE_MONITOR_ST_LF 4
`define FAIL_SAFE_MONITOR_ST_SEC 3
`define FAIL_SAFE_MONITOR_ST_ADC 2
`define FAIL_SAFE_MONITOR_ST_PLL 0
`define FAIL_SAFE_MONITOR_ST_MASK 8'hFD
`define FAIL_SAFE_MONITOR_FAIL_FLAG 0
`define FAIL_SAFE_MONITOR_FAIL_IE 1
`define FAIL_SAFE_MONITOR_FAIL_ACTIVE 2
`define FAIL_SAFE_MONITOR_LF_DIV 64
`define FAIL_SAFE_MONITOR_LF_CNT_W 6
`define FAIL_SAFE_MONITOR_LF_RISE 6'h3F
`define FAIL_SAFE_MONITOR_LF_FALL 6'h1F
`define FAIL_SAFE_MONITOR_OST_DEFAULT 1024
`define FAIL_SAFE_MONITOR_SWCTRL_RST 8'h00
`define FAIL_SAFE_MONITOR_ZERO8 8'h00
`endif

/* File: tb/fail_safe_monitor_assertions.sv */
// assertions on the ports of the clock monitor and switch
`timescale 1ns/10ps
module fail_safe_monitor_assertions (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // bus handshake
  input wire read,
  input wire write,
  input wire waitrequest,
  // power management
  input wire sleep_pulse,
  // clock selection and events
  input wire [2:0] system_source,
  input wire [3:0] system_divider,
  input wire switch_hold_request,
  input wire fail_safe_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence fail_entry;
    $rose(fail_safe_active);
  endsequence
  sequence on_high_freq;
    system_source == 3'h6;
  endsequence
  chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus access waited more than one cycle");
  chk_fail_source: assert property (fail_entry |-> on_high_freq)
    else $error("failover did not select the high-freq source");
  chk_fail_divider: assert property (fail_entry |-> $stable(system_divider))
    else $error("failover changed the divider");
  chk_fail_external: assert property (fail_entry |-> $past(system_source) inside {3'h7, 3'h2, 3'h4})
    else $error("failover from a source that is not monitored");
  chk_stay_internal: assert property (fail_safe_active && $past(fail_safe_active) |-> system_source == 3'h6)
    else $error("source left high-freq during fail-safe");
  chk_source_legal: assert property (!(system_source inside {3'h0, 3'h1, 3'h3}))
    else $error("reserved source code selected");
  chk_hold_stable: assert property (switch_hold_request && $past(switch_hold_request) |-> $stable(system_source))
    else $error("source moved while the switch was held");
  chk_sleep_clear: assert property (sleep_pulse && fail_safe_active |=> !fail_safe_active)
    else $error("sleep did not clear fail-safe");
endmodule // fail_safe_monitor_assertions
bind fail_safe_monitor_top fail_safe_monitor_assertions fail_safe_monitor_assertions_inst (.clk(clk), .arst_n(arst_n), .read(read), .write(write),
  .waitrequest(waitrequest), .sleep_pulse(sleep_pulse), .system_source(system_source),
  .system_divider(system_divider), .switch_hold_request(switch_hold_request), .fail_safe_active(fail_safe_active));

/* File: tb/fail_safe_monitor_ext_osc.sv */
// external crystal model whose oscillation can be stopped
`timescale 1ns/10ps
module fail_safe_monitor_ext_osc #(
  parameter HALF_NS = 160
) (
  // control from the bench
  input wire run,
  // oscillator pin and ready indication
  output logic ext_clk,
  output logic ext_ready
);
  initial ext_clk = 1'b1;
  // a dead crystal parks high, so no falling edge reaches the monitor
  always
  begin
    #(HALF_NS);
    ext_clk = run ? ~ext_clk : 1'b1;
  end
  assign ext_ready = run;
endmodule // fail_safe_monitor_ext_osc

/* File: tb/test_fail_safe_monitor_top.sv */
// self-checking bench for the clock monitor and switch
`timescale 1ns/10ps
`include "fail_safe_monitor_defines.vh"
module test_fail_safe_monitor_top;
  logic clk;
  logic arst_n;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  wire [31:0] readdata;
  wire waitrequest;
  wire ext_clk;
  wire ext_ready;
  logic lf_osc;
  logic [5:0] rnd_bits;
  logic run;
  logic allow;
  logic [2:0] strap;
  logic sleep_pulse;
  wire [2:0] system_source;
  wire [3:0] system_divider;
  wire hf64;
  wire sec_hp;
  logic ecm;
  wire osc_fail_request;
  wire switch_hold_request;
  wire fail_safe_active;
  logic [31:0] exp_q[$];
  logic [31:0] seed;
  logic [3:0] dv;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  fail_safe_monitor_top #(.OST_COUNT(8)) fail_safe_monitor_top_inst (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
    .ext_clk(ext_clk), .low_freq_internal_osc(lf_osc), .osc_ready_in({ext_ready, 1'b1, rnd_bits}),
    .fail_monitor_enable(1'b1), .switch_allow_config(allow), .external_clock_input_mode(ecm),
    .reset_source_config(strap), .sleep_pulse(sleep_pulse), .system_source(system_source),
    .system_divider(system_divider), .secondary_high_power(sec_hp), .high_freq_64m_default(hf64),
    .osc_fail_request(osc_fail_request), .switch_hold_request(switch_hold_request),
    .fail_safe_active(fail_safe_active));
  fail_safe_monitor_ext_osc fail_safe_monitor_ext_osc_inst (.run(run), .ext_clk(ext_clk), .ext_ready(ext_ready));
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // holds the request until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    bus(1'b0, a, 8'h00);
  endtask
  task wait_src(input logic [2:0] s);
    while (system_source !== s) @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // low-freq osc kept fast so a sample period is a few hundred cycles
  initial
  begin
    lf_osc = 1'b0;
    #13;
    forever #200 lf_osc = ~lf_osc;
  end
  always @(posedge clk)
  begin
    if (read === 1'b1 && waitrequest === 1'b0)
      check(readdata, exp_q.pop_front());
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    seed = xs(32'd93);
    rnd_bits = seed[5:0];
    seed = xs(seed);
    dv = 4'd2 + 4'(seed % 8);
    arst_n = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    run = 1'b1;
    allow = 1'b1;
    ecm = 1'b0;
    strap = 3'b110;
    sleep_pulse = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`FAIL_SAFE_MONITOR_OFS_REQUEST, {1'b0, `FAIL_SAFE_MONITOR_SRC_HF, `FAIL_SAFE_MONITOR_DIV_4});
    rd(`FAIL_SAFE_MONITOR_OFS_CURRENT, {1'b0, `FAIL_SAFE_MONITOR_SRC_HF, `FAIL_SAFE_MONITOR_DIV_4});
    rd(`FAIL_SAFE_MONITOR_OFS_SWCTRL, 8'h10);
    rd(`FAIL_SAFE_MONITOR_OFS_STATUS, {2'b11, rnd_bits[5:2], 1'b0, rnd_bits[0]});
    rd(5'h14, 8'h00);
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_SWCTRL, 8'h40);
    rd(`FAIL_SAFE_MONITOR_OFS_SWCTRL, 8'h50);
    check(32'(sec_hp), 32'h1);
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, `FAIL_SAFE_MONITOR_OFS_REQUEST,
          {1'b0, ((i == 0) ? `FAIL_SAFE_MONITOR_SRC_RSV0 : ((i == 1) ? `FAIL_SAFE_MONITOR_SRC_RSV1 : `FAIL_SAFE_MONITOR_SRC_RSV3)), 4'h5});
      rd(`FAIL_SAFE_MONITOR_OFS_REQUEST, 8'h62);
    end
    $display("test reserved done");
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_REQUEST, {1'b0, `FAIL_SAFE_MONITOR_SRC_EXT, dv});
    check(32'(system_source), 32'h6);
    wait_src(`FAIL_SAFE_MONITOR_SRC_EXT);
    rd(`FAIL_SAFE_MONITOR_OFS_CURRENT, {1'b0, `FAIL_SAFE_MONITOR_SRC_EXT, dv});
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_FAIL, 8'h02);
    $display("test switch done");
    run <= 1'b0;
    while (fail_safe_active !== 1'b1) @(posedge clk);
    check(32'(system_source), 32'h6);
    check(32'(system_divider), 32'(dv));
    check(32'(osc_fail_request), 32'h1);
    rd(`FAIL_SAFE_MONITOR_OFS_FAIL, 8'h07);
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_FAIL, 8'h03);
    rd(`FAIL_SAFE_MONITOR_OFS_FAIL, 8'h06);
    $display("test failover done");
    run <= 1'b1;
    sleep_pulse <= 1'b1;
    @(posedge clk);
    sleep_pulse <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(fail_safe_active), 32'h0);
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_REQUEST, 8'h71);
    while (system_source !== 3'h7 || system_divider !== 4'h1) @(posedge clk);
    rd(`FAIL_SAFE_MONITOR_OFS_FAIL, 8'h02);
    $display("test recovery done");
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_SWCTRL, 8'hC0);
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_REQUEST, 8'h60);
    while (switch_hold_request !== 1'b1) @(posedge clk);
    check(32'(system_source), 32'h7);
    rd(`FAIL_SAFE_MONITOR_OFS_SWCTRL, 8'hC8);
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_SWCTRL, 8'h40);
    wait_src(`FAIL_SAFE_MONITOR_SRC_HF);
    rd(`FAIL_SAFE_MONITOR_OFS_SWCTRL, 8'h50);
    $display("test hold done");
    ecm <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_REQUEST, {1'b0, `FAIL_SAFE_MONITOR_SRC_EXT, `FAIL_SAFE_MONITOR_DIV_1});
    // with the start-up timer running this would still read the old source
    repeat (8) @(posedge clk);
    check(32'(system_source), 32'h7);
    $display("test clock input mode done");
    allow <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, `FAIL_SAFE_MONITOR_OFS_REQUEST, 8'h50);
    rd(`FAIL_SAFE_MONITOR_OFS_REQUEST, 8'h70);
    strap <= 3'b000;
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(`FAIL_SAFE_MONITOR_OFS_REQUEST, {1'b0, `FAIL_SAFE_MONITOR_SRC_HF, `FAIL_SAFE_MONITOR_DIV_1});
    check(32'(hf64), 32'h1);
    $display("test lock and strap done");
    @(posedge clk);
    results();
  end
endmodule // test_fail_safe_monitor_top
